/* File: hw/prs_ref_select.sv */
// Reference select, loss detection, dividers and tuning gate
// Assumes pins are asynchronous to clk and edges are slower than clk/2
`timescale 1ns/10ps
`default_nettype none
module prs_ref_select
  import prs_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic prog_clk,
  input  wire logic prog_data,
  input  wire logic prog_le,
  input  wire logic ref_input_zero,
  input  wire logic ref_input_one,
  input  wire logic oscillator_input,
  input  wire logic first_loop_lock,
  output var  logic ref0_buf_mos,
  output var  logic ref1_buf_mos,
  output var  logic ref_sel,
  output var  logic ref_div_pulse,
  output var  logic fb_div_pulse,
  output var  logic tune_start,
  output var  logic ref0_loss_out_o,
  output var  logic ref0_loss_out_oe,
  output var  logic ref1_loss_out_o,
  output var  logic ref1_loss_out_oe
);
  // ******************************
  // Pin synchronisers
  // ******************************
  localparam int NS = 7;
  logic [NS-1:0] pin_in;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [NS-1:0] s3_r;
  wire  [NS-1:0] rise = s2_r & ~s3_r;
  assign pin_in = {first_loop_lock, oscillator_input, ref_input_one,
                   ref_input_zero, prog_le, prog_data, prog_clk};
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= pin_in[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
        end
      end
    end
  endgenerate
  wire lock_s = s2_r[6];
  wire [1:0] ref_edge = rise[4:3];

  // ******************************
  // Serial configuration port
  // ******************************
  logic [31:0] shift_r;
  wire  [3:0]  addr   = shift_r[ADDR_LSB +: 4];
  wire         latch  = rise[2];
  wire         wr_rst = latch && addr == REG_SW_RESET && shift_r[SW_RST_B];
  wire         wr_tun = latch && addr == REG_TUNE_CTRL;
  wire         wr_ref = latch && addr == REG_REF_CFG;
  wire         wr_div = latch && addr == REG_DIV_CFG;
  wire         wr_fb2 = latch && addr == REG_FB2_DIV;
  wire prs_ref_cfg_type ref_wdata = shift_r[REF_LSB +: 8];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_r <= '0;
    end else if (rise[0]) begin
      shift_r <= {shift_r[30:0], s2_r[1]};
    end
  end

  prs_ref_cfg_type ref_cfg_r;
  logic [11:0]     rdiv_r;
  logic [11:0]     ndiv_r;
  logic            gate_r;
  // Reset bit is not stored, so it reads back clear by itself
  always_ff @(posedge clk) begin
    if (sys_rst || wr_rst) begin
      ref_cfg_r <= REF_CFG_RST;
      rdiv_r    <= DIV_RST;
      ndiv_r    <= DIV_RST;
      gate_r    <= GATE_RST;
    end else begin
      if (wr_ref) ref_cfg_r <= ref_wdata;
      if (wr_div) rdiv_r <= shift_r[RDIV_LSB +: DIV_W];
      if (wr_div) ndiv_r <= shift_r[NDIV_LSB +: DIV_W];
      if (wr_tun) gate_r <= shift_r[GATE_B];
    end
  end
  assign ref0_buf_mos = ref_cfg_r.buftype[0];
  assign ref1_buf_mos = ref_cfg_r.buftype[1];

  // ******************************
  // Loss detectors
  // ******************************
  function automatic logic [5:0] los_limit(input logic [1:0] t);
    unique case (t)
      2'h0: los_limit = LOS_LIM0;
      2'h1: los_limit = LOS_LIM1;
      2'h2: los_limit = LOS_LIM2;
      2'h3: los_limit = LOS_LIM3;
    endcase
  endfunction
  wire [5:0] lim = los_limit(ref_cfg_r.timeout);
  logic [LOS_CNT_W-1:0] los_cnt_r [2];
  logic [1:0]           los_r;
  // Sampling at 50 MHz cannot resolve edges near the 32 MHz setting
  generate
    for (g = 0; g < 2; g++) begin : g_los
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          los_cnt_r[g] <= '0;
          los_r[g]     <= 1'b1;
        end else if (ref_edge[g]) begin
          los_cnt_r[g] <= '0;
          los_r[g]     <= 1'b0;
        end else if (los_cnt_r[g] >= lim) begin
          los_r[g]     <= 1'b1;
        end else begin
          los_cnt_r[g] <= los_cnt_r[g] + 6'h01;
        end
      end
    end
  endgenerate

  // ******************************
  // Reference selection
  // ******************************
  wire nonrev_to1 = !ref_sel && los_r[0] && !los_r[1];
  wire nonrev_to0 = ref_sel && los_r[1] && !los_r[0];
  wire revert_sel = los_r[0] && !los_r[1];
  logic sel_nxt;
  always_comb begin
    sel_nxt = ref_sel;
    unique case (ref_cfg_r.sel)
      SEL_FORCE0: sel_nxt = 1'b0;
      SEL_FORCE1: sel_nxt = 1'b1;
      SEL_NONREV: sel_nxt = ref_sel ^ (nonrev_to1 || nonrev_to0);
      SEL_REVERT: sel_nxt = revert_sel;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst || wr_rst) begin
      ref_sel <= 1'b0;
    end else if (wr_ref) begin
      ref_sel <= (ref_wdata.sel == SEL_FORCE1);
    end else begin
      ref_sel <= sel_nxt;
    end
  end

  // Only the selected input reaches the reference divider
  wire sel_edge = ref_sel ? ref_edge[1] : ref_edge[0];
  prs_divider #(.W(DIV_W)) u_ref_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .en      (sel_edge),
    .div     (rdiv_r),
    .pulse   (ref_div_pulse)
  );
  // Runs whatever the tuning gate says
  prs_divider #(.W(DIV_W)) u_fb_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .en      (rise[5]),
    .div     (ndiv_r),
    .pulse   (fb_div_pulse)
  );

  // ******************************
  // Loss output pins
  // ******************************
  wire auto_mode = ref_cfg_r.sel[1];
  wire [1:0] los_show = auto_mode ? los_r : 2'h0;
  logic [1:0] lo_nxt;
  logic [1:0] oe_nxt;
  always_comb begin
    unique case (ref_cfg_r.los_mode)
      LOS_NMOS: begin
        lo_nxt = 2'h0;
        oe_nxt = ~los_show;
      end
      LOS_PMOS: begin
        lo_nxt = 2'h3;
        oe_nxt = los_show;
      end
      LOS_CMOS: begin
        lo_nxt = los_show;
        oe_nxt = 2'h3;
      end
      default: begin
        lo_nxt = 2'h0;
        oe_nxt = 2'h0;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {ref1_loss_out_o, ref0_loss_out_o}   <= 2'h0;
      {ref1_loss_out_oe, ref0_loss_out_oe} <= 2'h0;
    end else begin
      {ref1_loss_out_o, ref0_loss_out_o}   <= lo_nxt;
      {ref1_loss_out_oe, ref0_loss_out_oe} <= oe_nxt;
    end
  end

  // ******************************
  // Oscillator tuning gate
  // ******************************
  prs_tune_state_type st_r;
  prs_tune_state_type st_nxt;
  wire fire = (wr_fb2 && !gate_r) || (st_r == TUNE_WAIT && lock_s);
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      TUNE_IDLE: if (wr_fb2 && gate_r) st_nxt = TUNE_WAIT;
      TUNE_WAIT: if (lock_s) st_nxt = TUNE_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst || wr_rst) begin
      st_r       <= TUNE_IDLE;
      tune_start <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      tune_start <= fire;
    end
  end

  // ******************************
  // Checks
  // ******************************
  AST_TUNE_NOW: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_fb2 && !gate_r && !wr_rst) |=> tune_start)
    else $error("Ungated tuning not launched");
  AST_TUNE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == TUNE_WAIT && !lock_s) |=> !tune_start)
    else $error("Tuning started before lock");
  AST_FORCE0: assert property (@(posedge clk) disable iff (sys_rst)
    (ref_cfg_r.sel == SEL_FORCE0) |-> !ref_sel)
    else $error("Forced input 0 not held");
  AST_FORCE1: assert property (@(posedge clk) disable iff (sys_rst)
    (ref_cfg_r.sel == SEL_FORCE1) |-> ref_sel)
    else $error("Forced input 1 not held");
  AST_AUTO_START: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_ref && ref_wdata.sel[1] && !wr_rst) |=> !ref_sel)
    else $error("Automatic mode did not start on input 0");
  AST_NONREV: assert property (@(posedge clk) disable iff (sys_rst)
    (ref_cfg_r.sel == SEL_NONREV && ref_sel && !los_r[1] && !latch)
    |=> ref_sel) else $error("Non-revertive left a good input");
  AST_REVERT: assert property (@(posedge clk) disable iff (sys_rst)
    (ref_cfg_r.sel == SEL_REVERT && !los_r[0] && !latch) |=> !ref_sel)
    else $error("Revertive did not return to input 0");
  AST_LOS_SET: assert property (@(posedge clk) disable iff (sys_rst)
    (!ref_edge[0] [*2] ##0 los_cnt_r[0] >= lim) |=> los_r[0])
    else $error("Loss not declared on timeout");
  AST_LOS_CLR: assert property (@(posedge clk) disable iff (sys_rst)
    ref_edge[1] |=> !los_r[1]) else $error("Loss not cleared on edge");
  // Forced modes must show the no-loss level of whatever driver is chosen
  AST_LOS_PIN: assert property (@(posedge clk) disable iff (sys_rst)
    (!auto_mode && !latch) |=>
    (ref0_loss_out_oe == ref_cfg_r.los_mode[0] &&
     ref0_loss_out_o == (ref_cfg_r.los_mode == LOS_PMOS)))
    else $error("Loss pin active in forced mode");
  AST_SWRST: assert property (@(posedge clk) disable iff (sys_rst)
    wr_rst |=> (ref_cfg_r == REF_CFG_RST && rdiv_r == DIV_RST && !gate_r))
    else $error("Software reset left configuration");
  COV_GATED_TUNE: cover property (@(posedge clk) disable iff (sys_rst)
    st_r == TUNE_WAIT ##1 tune_start);
  COV_NONREV_SWITCH: cover property (@(posedge clk) disable iff (sys_rst)
    ref_cfg_r.sel == SEL_NONREV && $rose(ref_sel));
  COV_REVERT_BACK: cover property (@(posedge clk) disable iff (sys_rst)
    ref_cfg_r.sel == SEL_REVERT && $fell(ref_sel));
endmodule // prs_ref_select
`default_nettype wire

/* File: hw/prs_pkg.sv */
// Constants, field layouts and carrier types of the reference select block
// Assumes a 50 MHz system clock and a serial configuration port
// Summary of operation
// - Gated start set: hold oscillator tuning until first loop lock is valid.
// - Gated start clear: tune right after each second loop divider write.
// - Gated start clear still lets the first loop divide and lock.
// - Buffer type bit 0 steers input 0, bit 1 input 1; 1 means MOS.
// - Select code 00 forces input 0, code 01 forces input 1.
// - Both automatic modes start with input 0 selected.
// - Non-revertive: switch only when the selected input fails.
// - Revertive: use input 0 whenever active or when both are lost, else input 1.
// - Automatic decisions look only at the two loss indications.
// - Loss pins carry input state only in automatic modes.
// - Shared timeout field picks minimum frequency 1, 3.0, 13 or 32 MHz.
// - Loss output mode: 01 NMOS drain, 10 PMOS drain, 11 CMOS.
// - Feedback divider is 12 bits, divides 1 to 4095, zero invalid.
// - Reference divider is 12 bits, divides 1 to 4095, zero invalid.
// - Software reset bit returns all configuration to power-on values.
package prs_pkg;
  // ******************************
  // Clock and timing
  // ******************************
  localparam int CLK_KHZ      = 50000;
  localparam int LOS_F0_KHZ   = 1000;
  localparam int LOS_F1_KHZ   = 3000;
  localparam int LOS_F2_KHZ   = 13000;
  localparam int LOS_F3_KHZ   = 32000;
  localparam int LOS_CNT_W    = 6;
  // Least window rounds up to whole cycles
  localparam logic [5:0] LOS_LIM0 = 6'((CLK_KHZ + LOS_F0_KHZ - 1) / LOS_F0_KHZ);
  localparam logic [5:0] LOS_LIM1 = 6'((CLK_KHZ + LOS_F1_KHZ - 1) / LOS_F1_KHZ);
  localparam logic [5:0] LOS_LIM2 = 6'((CLK_KHZ + LOS_F2_KHZ - 1) / LOS_F2_KHZ);
  localparam logic [5:0] LOS_LIM3 = 6'((CLK_KHZ + LOS_F3_KHZ - 1) / LOS_F3_KHZ);
  // ******************************
  // Register numbers and fields
  // ******************************
  localparam logic [3:0] REG_SW_RESET   = 4'h7;
  localparam logic [3:0] REG_TUNE_CTRL  = 4'ha;
  localparam logic [3:0] REG_REF_CFG    = 4'hb;
  localparam logic [3:0] REG_DIV_CFG    = 4'hc;
  localparam logic [3:0] REG_FB2_DIV    = 4'hf;
  localparam int ADDR_LSB  = 0;
  localparam int SW_RST_B  = 17;
  localparam int GATE_B    = 4;
  localparam int REF_LSB   = 4;
  localparam int RDIV_LSB  = 4;
  localparam int NDIV_LSB  = 16;
  localparam int DIV_W     = 12;
  localparam logic [1:0] SEL_FORCE0 = 2'h0;
  localparam logic [1:0] SEL_FORCE1 = 2'h1;
  localparam logic [1:0] SEL_NONREV = 2'h2;
  localparam logic [1:0] SEL_REVERT = 2'h3;
  localparam logic [1:0] LOS_NMOS   = 2'h1;
  localparam logic [1:0] LOS_PMOS   = 2'h2;
  localparam logic [1:0] LOS_CMOS   = 2'h3;

  typedef struct packed {
    logic [1:0] los_mode;
    logic [1:0] timeout;
    logic [1:0] sel;
    logic [1:0] buftype;
  } prs_ref_cfg_type;

  localparam prs_ref_cfg_type REF_CFG_RST = '0;
  localparam logic [11:0] DIV_RST  = 12'h001;
  localparam logic        GATE_RST = 1'b0;

  typedef enum logic [0:0] {
    TUNE_IDLE = 1'b0,
    TUNE_WAIT = 1'b1
  } prs_tune_state_type;
endpackage

/* File: hw/prs_divider.sv */
// Programmable edge divider for the first loop
// Assumes en is a one-cycle edge pulse on clk
`timescale 1ns/10ps
`default_nettype none
module prs_divider
  import prs_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         en,
  input  wire logic [W-1:0] div,
  output var  logic         pulse
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire          wrap = (cnt_r >= div - W'(1));
  // Zero is invalid and gives no output at all
  assign cnt_nxt = wrap ? '0 : cnt_r + W'(1);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      pulse <= 1'b0;
    end else begin
      pulse <= en && (div != '0) && wrap;
      if (en) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  AST_DIV_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    pulse |-> $past(div) != '0) else $error("Divider output at zero");
  AST_DIV_CNT: assert property (@(posedge clk) disable iff (sys_rst)
    (en && div != '0 && cnt_r == div - W'(1)) |=> pulse)
    else $error("Divider missed its count");
endmodule // prs_divider
`default_nettype wire

/* File: testbench/prs_ref_source.sv */
// Partner model: two reference clocks and the oscillator clock
// Assumes the bench starts and stops each reference by its run input
`timescale 1ns/10ps
`default_nettype none
module prs_ref_source #(
  parameter int REF_HALF = 200,
  parameter int OSC_HALF = 100
) (
  input  wire logic run0,
  input  wire logic run1,
  output var  logic ref0,
  output var  logic ref1,
  output var  logic osc
);
  initial begin
    ref0 = 1'b0;
    ref1 = 1'b0;
    osc  = 1'b0;
  end
  // A stopped reference stands still, which is what a lost input looks like
  always #(REF_HALF) if (run0) ref0 = ~ref0;
  always #(REF_HALF) if (run1) ref1 = ~ref1;
  always #(OSC_HALF) osc = ~osc;
endmodule // prs_ref_source
`default_nettype wire

/* File: testbench/pll1_reference_select_ctrl_bench.sv */
// Bench for the reference select block: serial writes, pin checks
// Assumes references at 2.5 MHz and oscillator at 5 MHz from the partner
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end
module pll1_reference_select_ctrl_bench;
  import prs_pkg::*;
  logic clk, sys_rst, prog_clk, prog_data, prog_le, lock, run0, run1;
  logic ref0, ref1, osc, b0, b1, sel, rdp, fdp, tune, l0o, l0e, l1o, l1e;
  int   fails, cmp_count, tune_cnt, c, c0;
  prs_ref_source src (.run0(run0), .run1(run1), .ref0(ref0), .ref1(ref1),
    .osc(osc));
  prs_ref_select dut (.clk(clk), .sys_rst(sys_rst), .prog_clk(prog_clk),
    .prog_data(prog_data), .prog_le(prog_le), .ref_input_zero(ref0),
    .ref_input_one(ref1), .oscillator_input(osc), .first_loop_lock(lock),
    .ref0_buf_mos(b0), .ref1_buf_mos(b1), .ref_sel(sel),
    .ref_div_pulse(rdp), .fb_div_pulse(fdp), .tune_start(tune),
    .ref0_loss_out_o(l0o), .ref0_loss_out_oe(l0e),
    .ref1_loss_out_o(l1o), .ref1_loss_out_oe(l1e));
  always #10 clk = ~clk;
  always @(posedge clk) if (tune === 1'b1) tune_cnt++;
  // ********************
  // Access tasks
  // ********************
  // Each pin level is held at least 4 cycles so the synchronisers never miss it
  task automatic wr(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      prog_data = w[i];
      repeat (4) @(negedge clk);
      prog_clk = 1'b1;
      repeat (4) @(negedge clk);
      prog_clk = 1'b0;
    end
    prog_le = 1'b1;
    repeat (4) @(negedge clk);
    prog_le = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic wr_cfg(input logic [1:0] m, t, s, bt);
    wr({20'h0_0000, m, t, s, bt, REG_REF_CFG});
  endtask
  function automatic logic exp_oe(input logic [1:0] m, input logic f);
    return (m == LOS_NMOS) ? ~f : (m == LOS_PMOS) ? f : (m == LOS_CMOS);
  endfunction
  function automatic logic exp_o(input logic [1:0] m, input logic f);
    return (m == LOS_PMOS) | ((m == LOS_CMOS) & f);
  endfunction
  task automatic chk_los(input logic [1:0] m, input logic f0, f1);
    `CHK({l0e, l1e}, {exp_oe(m, f0), exp_oe(m, f1)})
    `CHK({l0o, l1o}, {exp_o(m, f0), exp_o(m, f1)})
  endtask
  // Cycles from now to the next pulse of a divider output, bounded
  task automatic gap(input logic fb, output int n);
    n = 0;
    while (n < 300 && (fb ? fdp : rdp) !== 1'b1) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic spacing(input logic fb, input int exp);
    gap(fb, c);
    @(negedge clk);
    gap(fb, c);
    `CHK(c + 1, exp)
  endtask
  task automatic summarize;
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ********************
  // Sequence
  // ********************
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    {clk, prog_clk, prog_data, prog_le, lock} = 5'h00;
    {sys_rst, run0, run1, fails, cmp_count, tune_cnt} = {3'h7, 96'h0};
    repeat (8) @(negedge clk);
    `CHK({b0, b1, sel, rdp, fdp, tune, l0e, l1e}, 8'h00)
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    wr_cfg(2'h0, 2'h0, SEL_FORCE0, 2'h1);
    `CHK({b1, b0}, 2'h1)
    wr_cfg(2'h0, 2'h0, SEL_FORCE1, 2'h2);
    `CHK({b1, b0, sel}, 3'h5)
    run1 = 1'b0;
    repeat (150) @(negedge clk);
    `CHK({sel, l0e, l1e}, 3'h4)
    wr_cfg(2'h0, 2'h0, SEL_FORCE0, 2'h0);
    run0 = 1'b0;
    run1 = 1'b1;
    repeat (150) @(negedge clk);
    `CHK(sel, 1'b0)
    for (int m = 1; m < 4; m++) begin
      wr_cfg(2'(m), 2'h0, SEL_NONREV, 2'h0);
      chk_los(2'(m), 1'b1, 1'b0);
      `CHK(sel, 1'b1)
    end
    run0 = 1'b1;
    repeat (150) @(negedge clk);
    `CHK(sel, 1'b1)
    run1 = 1'b0;
    repeat (150) @(negedge clk);
    `CHK(sel, 1'b0)
    chk_los(LOS_CMOS, 1'b0, 1'b1);
    run1 = 1'b1;
    wr_cfg(LOS_CMOS, 2'h0, SEL_REVERT, 2'h3);
    `CHK(sel, 1'b0)
    run0 = 1'b0;
    repeat (150) @(negedge clk);
    `CHK(sel, 1'b1)
    run0 = 1'b1;
    repeat (150) @(negedge clk);
    `CHK(sel, 1'b0)
    wr({4'h0, 12'h005, 12'h003, REG_DIV_CFG});
    spacing(1'b0, 60);
    spacing(1'b1, 50);
    wr({4'h0, 12'h000, 12'h001, REG_DIV_CFG});
    spacing(1'b0, 20);
    gap(1'b1, c);
    `CHK(c, 300)
    c0 = tune_cnt;
    wr({28'h000_0000, REG_FB2_DIV});
    `CHK(tune_cnt, c0 + 1)
    wr({27'h000_0000, 1'b1, REG_TUNE_CTRL});
    wr({28'h000_0000, REG_FB2_DIV});
    repeat (40) @(negedge clk);
    `CHK(tune_cnt, c0 + 1)
    lock = 1'b1;
    repeat (10) @(negedge clk);
    `CHK(tune_cnt, c0 + 2)
    // A 2.5 MHz input is only good enough for the 1 MHz threshold
    for (int t = 0; t < 4; t++) begin
      wr_cfg(LOS_CMOS, 2'(t), SEL_REVERT, 2'h3);
      c = 0;
      repeat (40) begin
        @(negedge clk);
        if (l0o === 1'b1) c++;
      end
      `CHK(c > 0, t != 0)
    end
    lock = 1'b0;
    wr({14'h0000, 1'b1, 13'h0000, REG_SW_RESET});
    `CHK({b1, b0, sel, l0e, l1e}, 5'h00)
    wr({28'h000_0000, REG_FB2_DIV});
    `CHK(tune_cnt, c0 + 3)
    summarize();
  end
endmodule // pll1_reference_select_ctrl_bench
`default_nettype wire
